// File: logic/servo_stop_mode_selector.sv
// Operation
// RQ1: Quick-stop setting is signed, legal 0 to 7, reset value 2.
// RQ2: Quick-stop 0..3 stop by coast, profile, quick ramp or torque, then off.
// RQ3: Quick-stop 5..7 stop as 1..3 then hold position lock; 4 is illegal.
// RQ4: Brake enabled and quick-stop below 4 forces quick ramp then off.
// RQ5: Servo-off setting is signed, legal -4 to 2, reset value 0.
// RQ6: Servo-off -4..-1 stop by several methods then keep dynamic braking.
// RQ7: Servo-off 0..2 stop by coast, profile ramp or braking, then off.
// RQ8: Halt setting is 1 to 3, reset 1, and always ends in position lock.
// RQ9: In profile torque mode every halt value uses the torque slope.
// RQ10: Fault-stop setting is signed, legal -5 to 4, reset value 2.
// RQ11: Fault-stop -5..-1 stop by several methods then keep braking.
// RQ12: Fault-stop 0..4 stop by several methods then leave the motor off.
// RQ13: Brake output enabled forces fault stops to quick ramp and braking.
// RQ14: Mode selector is a byte, reset 0, accepting 1,3,4,6,8,9,10.
// RQ15: A bad mode is refused with an error by service data, ignored by PDO.
// RQ16: The mode in effect is shown in a separate read-only object.
// RQ17: Stop settings change only while the motor is stopped.
module servo_stop_mode_selector (
    input  wire logic                         ref_clk,      // Drive clock.
    input  wire logic                         rst_n,        // Async reset.
    input  wire logic                         objWrite,     // Write strobe.
    input  wire logic                         objRead,      // Read strobe.
    input  wire logic                         objViaPdo,    // Cyclic path.
    input  wire logic [15:0]                  objIndex,     // Object index.
    input  wire logic [15:0]                  objWdata,     // Write data.
    output logic      [15:0]                  objRdata,     // Read data.
    output logic                              objAck,       // Answer pulse.
    output logic                              objError,     // Refused.
    input  wire logic [15:0]                  driveStatus,  // State word.
    input  wire logic                         motorStopped, // Motor at rest.
    input  wire logic                         brakeEnable,  // Brake output.
    input  wire logic                         quickStopReq, // Quick stop.
    input  wire logic                         servoOffReq,  // Servo-on off.
    input  wire logic                         haltReq,      // Halt.
    input  wire logic                         faultReq,     // Class-two fault.
    output servo_stop_pkg::stop_method_t      stopMethod,   // Decel method.
    output servo_stop_pkg::final_state_t      finalState,   // After stop.
    output logic                              stopValid,    // New decision.
    output logic      [7:0]                   modeDisplay   // Mode in effect.
);

    logic [15:0] quickStop, next_quickStop;
    logic [15:0] servoOff, next_servoOff;
    logic [15:0] haltMode, next_haltMode;
    logic [15:0] faultStop, next_faultStop;
    logic [7:0]  opMode, next_opMode;
    logic [15:0] stateWord, next_stateWord;
    logic [7:0]  next_modeDisplay;
    logic [15:0] next_objRdata;
    logic        next_objAck, next_objError, next_stopValid;
    servo_stop_pkg::stop_method_t next_stopMethod, profRamp;
    servo_stop_pkg::final_state_t next_finalState;
    logic signed [15:0] wv, qs, so, hm, fs;
    logic        modeOk, stopObj, accept, refuse;

    assign wv = objWdata;
    assign qs = quickStop;
    assign so = servoOff;
    assign hm = haltMode;
    assign fs = faultStop;

    always_comb begin
        case (objWdata)
            16'(servo_stop_pkg::MODE_PROFILE_POSITION),
            16'(servo_stop_pkg::MODE_PROFILE_VELOCITY),
            16'(servo_stop_pkg::MODE_PROFILE_TORQUE),
            16'(servo_stop_pkg::MODE_HOMING),
            16'(servo_stop_pkg::MODE_CYCLIC_POSITION),
            16'(servo_stop_pkg::MODE_CYCLIC_VELOCITY),
            16'(servo_stop_pkg::MODE_CYCLIC_TORQUE): modeOk = 1'b1; // RQ14
            default: modeOk = 1'b0;
        endcase
    end

    // Object access: write checks, read mux, answer one cycle later.
    always_comb begin
        next_quickStop = quickStop;
        next_servoOff  = servoOff;
        next_haltMode  = haltMode;
        next_faultStop = faultStop;
        next_opMode    = opMode;
        next_stateWord = driveStatus;
        next_modeDisplay = opMode; // RQ16
        next_objRdata  = objRdata;
        next_objAck    = objWrite | objRead;
        next_objError  = 1'b0;
        stopObj = 1'b0;
        accept  = 1'b0;
        case (objIndex)
            servo_stop_pkg::OBJ_QUICK_STOP: begin
                stopObj = 1'b1;
                accept  = wv >= 0 && wv <= 7 && wv != 4; // RQ1 RQ3
            end
            servo_stop_pkg::OBJ_SERVO_OFF: begin
                stopObj = 1'b1;
                accept  = wv >= -4 && wv <= 2; // RQ5
            end
            servo_stop_pkg::OBJ_HALT: begin
                stopObj = 1'b1;
                accept  = wv >= 1 && wv <= 3; // RQ8
            end
            servo_stop_pkg::OBJ_FAULT_STOP: begin
                stopObj = 1'b1;
                accept  = wv >= -5 && wv <= 4; // RQ10
            end
            servo_stop_pkg::OBJ_MODE_SELECT: accept = modeOk; // RQ14
            default: accept = 1'b0;
        endcase
        if (stopObj && !motorStopped) begin
            accept = 1'b0; // RQ17
        end
        // Bad values over the cyclic path are dropped silently.
        refuse = !accept && !objViaPdo; // RQ15
        if (objWrite) begin
            next_objError = refuse;
            if (accept) begin
                case (objIndex)
                    servo_stop_pkg::OBJ_QUICK_STOP:  next_quickStop = objWdata;
                    servo_stop_pkg::OBJ_SERVO_OFF:   next_servoOff = objWdata;
                    servo_stop_pkg::OBJ_HALT:        next_haltMode = objWdata;
                    servo_stop_pkg::OBJ_FAULT_STOP:  next_faultStop = objWdata;
                    servo_stop_pkg::OBJ_MODE_SELECT:
                        next_opMode = objWdata[7:0];
                    default: next_opMode = opMode;
                endcase
            end
        end else if (objRead) begin
            next_objRdata = 16'h0000;
            case (objIndex)
                servo_stop_pkg::OBJ_STATE_WORD:   next_objRdata = stateWord;
                servo_stop_pkg::OBJ_QUICK_STOP:   next_objRdata = quickStop;
                servo_stop_pkg::OBJ_SERVO_OFF:    next_objRdata = servoOff;
                servo_stop_pkg::OBJ_HALT:         next_objRdata = haltMode;
                servo_stop_pkg::OBJ_FAULT_STOP:   next_objRdata = faultStop;
                servo_stop_pkg::OBJ_MODE_SELECT:
                    next_objRdata = {8'h00, opMode};
                servo_stop_pkg::OBJ_MODE_DISPLAY:
                    next_objRdata = {8'h00, modeDisplay};
                default: next_objError = 1'b1;
            endcase
        end
    end

    // Stop decision; a fault outranks quick stop, servo-off and halt.
    always_comb begin
        profRamp = (modeDisplay == servo_stop_pkg::MODE_HOMING) ?
                   servo_stop_pkg::METHOD_HOMING_RAMP :
                   servo_stop_pkg::METHOD_PROFILE_RAMP; // RQ2
        next_stopMethod = stopMethod;
        next_finalState = finalState;
        next_stopValid  = faultReq | quickStopReq | servoOffReq | haltReq;
        if (faultReq) begin
            next_finalState = (fs < 0) ?
                              servo_stop_pkg::FINAL_DYNAMIC_BRAKING :
                              servo_stop_pkg::FINAL_DEENERGIZED; // RQ11 RQ12
            case (fs)
                -16'sd5: next_stopMethod = servo_stop_pkg::METHOD_ZERO_SPEED;
                -16'sd4:
                    next_stopMethod = servo_stop_pkg::METHOD_EMERGENCY_TORQUE;
                -16'sd3: next_stopMethod = servo_stop_pkg::METHOD_QUICK_RAMP;
                -16'sd2: next_stopMethod = profRamp;
                -16'sd1:
                    next_stopMethod = servo_stop_pkg::METHOD_DYNAMIC_BRAKE;
                16'sd0:  next_stopMethod = servo_stop_pkg::METHOD_COAST;
                16'sd1:  next_stopMethod = profRamp;
                16'sd2:  next_stopMethod = servo_stop_pkg::METHOD_QUICK_RAMP;
                16'sd3:
                    next_stopMethod = servo_stop_pkg::METHOD_EMERGENCY_TORQUE;
                default:
                    next_stopMethod = servo_stop_pkg::METHOD_DYNAMIC_BRAKE;
            endcase
            if (brakeEnable) begin // RQ13
                next_stopMethod = servo_stop_pkg::METHOD_QUICK_RAMP; // RQ13
                next_finalState = servo_stop_pkg::FINAL_DYNAMIC_BRAKING;
            end
        end else if (quickStopReq) begin
            next_finalState = (qs > 4) ? servo_stop_pkg::FINAL_POSITION_LOCK :
                              servo_stop_pkg::FINAL_DEENERGIZED; // RQ2 RQ3
            case (qs)
                16'sd0:         next_stopMethod = servo_stop_pkg::METHOD_COAST;
                16'sd1, 16'sd5: next_stopMethod = profRamp;
                16'sd2, 16'sd6:
                    next_stopMethod = servo_stop_pkg::METHOD_QUICK_RAMP;
                default:
                    next_stopMethod = servo_stop_pkg::METHOD_EMERGENCY_TORQUE;
            endcase
            if (brakeEnable && qs < 4) begin
                next_stopMethod = servo_stop_pkg::METHOD_QUICK_RAMP; // RQ4
                next_finalState = servo_stop_pkg::FINAL_DEENERGIZED; // RQ4
            end
        end else if (servoOffReq) begin
            next_finalState = (so < 0) ?
                              servo_stop_pkg::FINAL_DYNAMIC_BRAKING :
                              servo_stop_pkg::FINAL_DEENERGIZED; // RQ6 RQ7
            case (so)
                -16'sd4: next_stopMethod = servo_stop_pkg::METHOD_QUICK_RAMP;
                -16'sd3: next_stopMethod = servo_stop_pkg::METHOD_ZERO_SPEED;
                -16'sd2: next_stopMethod = profRamp;
                16'sd0:  next_stopMethod = servo_stop_pkg::METHOD_COAST;
                16'sd1:  next_stopMethod = profRamp;
                default:
                    next_stopMethod = servo_stop_pkg::METHOD_DYNAMIC_BRAKE;
            endcase
        end else if (haltReq) begin
            next_finalState = servo_stop_pkg::FINAL_POSITION_LOCK; // RQ8
            case (hm)
                16'sd2:  next_stopMethod = servo_stop_pkg::METHOD_QUICK_RAMP;
                16'sd3:
                    next_stopMethod = servo_stop_pkg::METHOD_EMERGENCY_TORQUE;
                default: next_stopMethod = profRamp;
            endcase
            if (modeDisplay == servo_stop_pkg::MODE_PROFILE_TORQUE) begin
                next_stopMethod = servo_stop_pkg::METHOD_TORQUE_SLOPE; // RQ9
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            quickStop   <= servo_stop_pkg::RST_QUICK_STOP;
            servoOff    <= servo_stop_pkg::RST_SERVO_OFF;
            haltMode    <= servo_stop_pkg::RST_HALT;
            faultStop   <= servo_stop_pkg::RST_FAULT_STOP;
            opMode      <= servo_stop_pkg::RST_MODE;
            stateWord   <= servo_stop_pkg::RST_STATE_WORD;
            modeDisplay <= servo_stop_pkg::RST_MODE;
            objRdata    <= 16'h0000;
            objAck      <= 1'b0;
            objError    <= 1'b0;
            stopMethod  <= servo_stop_pkg::METHOD_COAST;
            finalState  <= servo_stop_pkg::FINAL_NONE;
            stopValid   <= 1'b0;
        end else begin
            quickStop   <= next_quickStop;
            servoOff    <= next_servoOff;
            haltMode    <= next_haltMode;
            faultStop   <= next_faultStop;
            opMode      <= next_opMode;
            stateWord   <= next_stateWord;
            modeDisplay <= next_modeDisplay;
            objRdata    <= next_objRdata;
            objAck      <= next_objAck;
            objError    <= next_objError;
            stopMethod  <= next_stopMethod;
            finalState  <= next_finalState;
            stopValid   <= next_stopValid;
        end
    end

    property p_qs_range;
        @(posedge ref_clk) disable iff (!rst_n)
        objWrite && !objViaPdo && objIndex == servo_stop_pkg::OBJ_QUICK_STOP
            && objWdata == 16'h0004
        |=> objAck && objError && $stable(quickStop);
    endproperty
    a_qs_range: assert property (p_qs_range) // RQ1
        else $error("quick-stop value 4 was not refused");

    property p_qs_lock;
        @(posedge ref_clk) disable iff (!rst_n)
        quickStopReq && !faultReq && quickStop == 16'h0006
        |=> stopValid && stopMethod == servo_stop_pkg::METHOD_QUICK_RAMP
            && finalState == servo_stop_pkg::FINAL_POSITION_LOCK;
    endproperty
    a_qs_lock: assert property (p_qs_lock) // RQ3
        else $error("quick-stop 6 did not give ramp with position lock");

    property p_qs_brake;
        @(posedge ref_clk) disable iff (!rst_n)
        quickStopReq && !faultReq && brakeEnable && $signed(quickStop) < 4
        |=> stopMethod == servo_stop_pkg::METHOD_QUICK_RAMP
            && finalState == servo_stop_pkg::FINAL_DEENERGIZED;
    endproperty
    a_qs_brake: assert property (p_qs_brake) // RQ4
        else $error("brake did not force quick ramp on quick stop");

    property p_so_dyn;
        @(posedge ref_clk) disable iff (!rst_n)
        servoOffReq && !faultReq && !quickStopReq && $signed(servoOff) < 0
        |=> finalState == servo_stop_pkg::FINAL_DYNAMIC_BRAKING;
    endproperty
    a_so_dyn: assert property (p_so_dyn) // RQ6
        else $error("negative servo-off value did not keep braking");

    property p_halt_pt;
        @(posedge ref_clk) disable iff (!rst_n)
        haltReq && !faultReq && !quickStopReq && !servoOffReq
            && modeDisplay == servo_stop_pkg::MODE_PROFILE_TORQUE
        |=> stopMethod == servo_stop_pkg::METHOD_TORQUE_SLOPE
            && finalState == servo_stop_pkg::FINAL_POSITION_LOCK;
    endproperty
    a_halt_pt: assert property (p_halt_pt) // RQ9
        else $error("halt in torque mode did not use the torque slope");

    property p_fault_brake;
        @(posedge ref_clk) disable iff (!rst_n)
        faultReq && brakeEnable
        |=> stopMethod == servo_stop_pkg::METHOD_QUICK_RAMP
            && finalState == servo_stop_pkg::FINAL_DYNAMIC_BRAKING;
    endproperty
    a_fault_brake: assert property (p_fault_brake) // RQ13
        else $error("brake did not override the fault stop");

    property p_mode_pdo;
        @(posedge ref_clk) disable iff (!rst_n)
        objWrite && objViaPdo && objIndex == servo_stop_pkg::OBJ_MODE_SELECT
            && !modeOk
        |=> objAck && !objError && $stable(opMode);
    endproperty
    a_mode_pdo: assert property (p_mode_pdo) // RQ15
        else $error("bad cyclic mode write was not ignored");

    property p_mode_disp;
        @(posedge ref_clk) disable iff (!rst_n)
        objWrite && objIndex == servo_stop_pkg::OBJ_MODE_SELECT && modeOk
        |-> ##2 modeDisplay == $past(objWdata[7:0], 2);
    endproperty
    a_mode_disp: assert property (p_mode_disp) // RQ16
        else $error("mode display did not follow an accepted mode");

    property p_run_reject;
        @(posedge ref_clk) disable iff (!rst_n)
        objWrite && !objViaPdo && !motorStopped
            && objIndex == servo_stop_pkg::OBJ_FAULT_STOP
        |=> objError && $stable(faultStop);
    endproperty
    a_run_reject: assert property (p_run_reject) // RQ17
        else $error("stop setting changed while the motor ran");

endmodule // servo_stop_mode_selector

// File: logic/servo_stop_pkg.sv
package servo_stop_pkg;

    // Object indexes of the drive's dictionary.
    localparam logic [15:0] OBJ_STATE_WORD   = 16'h6041;
    localparam logic [15:0] OBJ_QUICK_STOP   = 16'h605a;
    localparam logic [15:0] OBJ_SERVO_OFF    = 16'h605c;
    localparam logic [15:0] OBJ_HALT         = 16'h605d;
    localparam logic [15:0] OBJ_FAULT_STOP   = 16'h605e;
    localparam logic [15:0] OBJ_MODE_SELECT  = 16'h6060;
    localparam logic [15:0] OBJ_MODE_DISPLAY = 16'h6061;

    // Reset values.
    localparam logic [15:0] RST_STATE_WORD = 16'h0000;
    localparam logic [15:0] RST_QUICK_STOP = 16'h0002;
    localparam logic [15:0] RST_SERVO_OFF  = 16'h0000;
    localparam logic [15:0] RST_HALT       = 16'h0001;
    localparam logic [15:0] RST_FAULT_STOP = 16'h0002;
    localparam logic [7:0]  RST_MODE       = 8'h00;

    // Operation mode codes.
    localparam logic [7:0] MODE_PROFILE_POSITION = 8'h01;
    localparam logic [7:0] MODE_PROFILE_VELOCITY = 8'h03;
    localparam logic [7:0] MODE_PROFILE_TORQUE   = 8'h04;
    localparam logic [7:0] MODE_HOMING           = 8'h06;
    localparam logic [7:0] MODE_CYCLIC_POSITION  = 8'h08;
    localparam logic [7:0] MODE_CYCLIC_VELOCITY  = 8'h09;
    localparam logic [7:0] MODE_CYCLIC_TORQUE    = 8'h0a;

    typedef enum logic [2:0] {
        METHOD_COAST,
        METHOD_PROFILE_RAMP,
        METHOD_HOMING_RAMP,
        METHOD_QUICK_RAMP,
        METHOD_EMERGENCY_TORQUE,
        METHOD_ZERO_SPEED,
        METHOD_DYNAMIC_BRAKE,
        METHOD_TORQUE_SLOPE
    } stop_method_t;

    typedef enum logic [1:0] {
        FINAL_NONE,
        FINAL_DEENERGIZED,
        FINAL_POSITION_LOCK,
        FINAL_DYNAMIC_BRAKING
    } final_state_t;

endpackage

// File: tb/host_ctrl_model.sv
module host_ctrl_model (
    input  wire logic        ref_clk,   // Drive clock.
    output logic             objWrite,  // Write strobe.
    output logic             objRead,   // Read strobe.
    output logic             objViaPdo, // Cyclic path.
    output logic      [15:0] objIndex,  // Object index.
    output logic      [15:0] objWdata,  // Write data.
    input  wire logic [15:0] objRdata,  // Read data.
    input  wire logic        objAck,    // Answer pulse.
    input  wire logic        objError   // Refused.
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        objWrite = 1'b0;
        objRead = 1'b0;
        objViaPdo = 1'b0;
        objIndex = 16'h0000;
        objWdata = 16'h0000;
    end

    // One request cycle; the answer is taken on the next falling edge.
    // Released index and data show the inverse so stale values cannot match.
    task automatic access(input logic wr, input logic pdo,
            input logic [15:0] idx, input logic [15:0] dat,
            output logic ack, output logic err, output logic [15:0] rd);
        @(negedge ref_clk);
        objWrite = wr;
        objRead = !wr;
        objViaPdo = pdo;
        objIndex = idx;
        objWdata = dat;
        @(negedge ref_clk);
        ack = objAck;
        err = objError;
        rd = objRdata;
        objWrite = 1'b0;
        objRead = 1'b0;
        objIndex = ~idx;
        objWdata = ~dat;
    endtask
endmodule // host_ctrl_model

// File: tb/servo_stop_mode_selector_tb_top.sv
module servo_stop_mode_selector_tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        objWrite, objRead, objViaPdo, objAck, objError;
    logic [15:0] objIndex, objWdata, objRdata;
    logic [15:0] driveStatus = 16'h0000;
    logic        motorStopped = 1'b1;
    logic        brakeEnable = 1'b0;
    logic [3:0]  evt = 4'h0;
    logic        stopValid;
    logic [7:0]  modeDisplay;
    int          errTotal = 0;
    int          nChecks = 0;
    int          st[5] = '{2, 0, 1, 2, 0};
    int          lo[5] = '{0, -4, 1, -5, 0};
    int          hi[5] = '{7, 2, 3, 4, 11};
    logic [15:0] idxs[5] = '{16'h605a, 16'h605c, 16'h605d, 16'h605e,
                             16'h6060};
    servo_stop_pkg::stop_method_t stopMethod;
    servo_stop_pkg::final_state_t finalState;

    always #10 ref_clk = ~ref_clk;

    servo_stop_mode_selector dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .objWrite(objWrite),
        .objRead(objRead), .objViaPdo(objViaPdo), .objIndex(objIndex),
        .objWdata(objWdata), .objRdata(objRdata), .objAck(objAck),
        .objError(objError), .driveStatus(driveStatus),
        .motorStopped(motorStopped), .brakeEnable(brakeEnable),
        .quickStopReq(evt[0]), .servoOffReq(evt[1]), .haltReq(evt[2]),
        .faultReq(evt[3]), .stopMethod(stopMethod),
        .finalState(finalState), .stopValid(stopValid),
        .modeDisplay(modeDisplay));

    host_ctrl_model host_u (
        .ref_clk(ref_clk), .objWrite(objWrite), .objRead(objRead),
        .objViaPdo(objViaPdo), .objIndex(objIndex), .objWdata(objWdata),
        .objRdata(objRdata), .objAck(objAck), .objError(objError));

    task automatic finalReport;
        $display("checks %0d mismatches %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    function automatic logic legal(int k, int v);
        if (k == 4)
            return v inside {1, 3, 4, 6, 8, 9, 10};
        return v >= lo[k] && v <= hi[k] && !(k == 0 && v == 4);
    endfunction

    // Returns the final state above the stop method.
    function automatic logic [4:0] expStop(int k, int v, logic brk);
        servo_stop_pkg::stop_method_t sm;
        servo_stop_pkg::stop_method_t pr;
        servo_stop_pkg::final_state_t fs;
        pr = servo_stop_pkg::METHOD_PROFILE_RAMP;
        if (8'(st[4]) == servo_stop_pkg::MODE_HOMING)
            pr = servo_stop_pkg::METHOD_HOMING_RAMP;
        fs = servo_stop_pkg::FINAL_DEENERGIZED;
        if (v < 0)
            fs = servo_stop_pkg::FINAL_DYNAMIC_BRAKING;
        sm = servo_stop_pkg::METHOD_COAST;
        case (k)
            0: begin
                if (brk && v < 4)
                    v = 2;
                if (v > 4)
                    fs = servo_stop_pkg::FINAL_POSITION_LOCK;
                case (v % 4)
                    1: sm = pr;
                    2: sm = servo_stop_pkg::METHOD_QUICK_RAMP;
                    3: sm = servo_stop_pkg::METHOD_EMERGENCY_TORQUE;
                    default: ;
                endcase
            end
            1: case (v)
                -4: sm = servo_stop_pkg::METHOD_QUICK_RAMP;
                -3: sm = servo_stop_pkg::METHOD_ZERO_SPEED;
                -2, 1: sm = pr;
                -1, 2: sm = servo_stop_pkg::METHOD_DYNAMIC_BRAKE;
                default: ;
            endcase
            2: begin
                fs = servo_stop_pkg::FINAL_POSITION_LOCK;
                sm = pr;
                if (v == 2)
                    sm = servo_stop_pkg::METHOD_QUICK_RAMP;
                if (v == 3)
                    sm = servo_stop_pkg::METHOD_EMERGENCY_TORQUE;
                if (8'(st[4]) == servo_stop_pkg::MODE_PROFILE_TORQUE)
                    sm = servo_stop_pkg::METHOD_TORQUE_SLOPE;
            end
            default: begin
                case (v)
                    -5: sm = servo_stop_pkg::METHOD_ZERO_SPEED;
                    -4, 3: sm = servo_stop_pkg::METHOD_EMERGENCY_TORQUE;
                    -3, 2: sm = servo_stop_pkg::METHOD_QUICK_RAMP;
                    -2, 1: sm = pr;
                    -1, 4: sm = servo_stop_pkg::METHOD_DYNAMIC_BRAKE;
                    default: ;
                endcase
                if (brk) begin
                    sm = servo_stop_pkg::METHOD_QUICK_RAMP;
                    fs = servo_stop_pkg::FINAL_DYNAMIC_BRAKING;
                end
            end
        endcase
        return {2'(fs), 3'(sm)};
    endfunction

    task automatic fire(input int k, input logic brk);
        logic [4:0] e;
        e = expStop(k, st[k], brk);
        @(negedge ref_clk);
        brakeEnable = brk;
        evt = 4'(1 << k);
        @(negedge ref_clk);
        evt = 4'h0;
        chk(16'(stopValid), 16'h0001);
        chk(16'({finalState, stopMethod}), 16'(e));
    endtask

    // Write an object, read it back, then check the mode in effect on the modeDisplay output.
    task automatic setObj(input int k, input int v, input logic pdo);
        logic        ok, a, e;
        logic [15:0] r;
        ok = legal(k, v) && (motorStopped || k == 4);
        host_u.access(1'b1, pdo, idxs[k], 16'(v), a, e, r);
        chk(16'({a, e}), 16'({1'b1, !ok && !pdo}));
        if (ok)
            st[k] = v;
        host_u.access(1'b0, 1'b0, idxs[k], 16'h0000, a, e, r);
        chk(r, 16'(st[k]));
        chk(16'(modeDisplay), 16'(8'(st[4])));
    endtask

    initial begin
        #1000000;
        errTotal++;
        finalReport();
    end

    initial begin
        logic        a, e;
        logic [15:0] r;
        int          k, v;
        void'($urandom(15485));
        driveStatus = 16'($urandom());
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        for (int i = 0; i < 5; i++) begin
            host_u.access(1'b0, 1'b0, idxs[i], 16'h0000, a, e, r);
            chk(r, 16'(st[i]));
        end
        host_u.access(1'b0, 1'b0, 16'h6041, 16'h0000, a, e, r);
        chk(r, driveStatus);
        host_u.access(1'b1, 1'b0, 16'h6041, 16'h0001, a, e, r);
        chk(16'({a, e}), 16'h0003);
        host_u.access(1'b0, 1'b0, 16'h6061, 16'h0000, a, e, r);
        chk(r, 16'h0000);
        host_u.access(1'b0, 1'b0, 16'h1234, 16'h0000, a, e, r);
        chk(16'({a, e}), 16'h0003);
        chk(r, 16'h0000);
        $display("test reset_values done, errors %0d", errTotal);
        for (int i = 0; i < 5; i++) begin
            for (int w = lo[i] - 1; w <= hi[i] + 1; w++) begin
                setObj(i, w, 1'($urandom_range(1)));
                for (int j = 0; j < 4; j++)
                    fire(j, 1'($urandom_range(1)));
            end
        end
        $display("test value_sweep done, errors %0d", errTotal);
        for (int n = 0; n < 300; n++) begin
            k = int'($urandom_range(4));
            motorStopped = ($urandom_range(3) != 0);
            v = lo[k] - 1 + int'($urandom_range(hi[k] - lo[k] + 2));
            setObj(k, v, 1'($urandom_range(1)));
            fire(int'($urandom_range(3)), 1'($urandom_range(1)));
            driveStatus = 16'($urandom());
            host_u.access(1'b0, 1'b0, 16'h6041, 16'h0000, a, e, r);
            chk(r, driveStatus);
            chk(16'({a, e}), 16'h0002);
        end
        $display("test random_mix done, errors %0d", errTotal);
        finalReport();
    end
endmodule // servo_stop_mode_selector_tb_top
